/* File: mcb_pkg.sv */
package mcb_pkg;
    // ==========================================================
    // register map (byte addresses, one aligned word each)
    localparam logic [7:0] MCB_BANK0_LOG_OFF = 8'h00;
    localparam logic [7:0] MCB_BANK2_LOG_OFF = 8'h04;
    localparam logic [7:0] MCB_BANK2_MASK_OFF = 8'h08;
    localparam logic [7:0] MCB_IRQ_STATUS_OFF = 8'h0c;
    localparam logic [7:0] MCB_IRQ_CLEAR_OFF = 8'h10;
    localparam logic [7:0] MCB_IRQ_ENABLE_OFF = 8'h14;
    localparam logic [7:0] MCB_LOG_CLEAR_OFF = 8'h18;
    localparam logic [7:0] MCB_QUEUE_OFF = 8'h1c;
    // ==========================================================
    // error log fields
    localparam int MCB_LOG_VALID_BIT = 0;
    localparam int MCB_LOG_UNCOR_BIT = 1;
    localparam int MCB_LOG_PCC_BIT = 2;
    localparam int MCB_LOG_OVER_BIT = 3;
    localparam int MCB_LOG_CODE_LSB = 16;
    localparam int MCB_CODE_W = 16;
    // ==========================================================
    // interrupt status bits
    localparam int MCB_EV_BANK0 = 0;
    localparam int MCB_EV_BANK2 = 1;
    localparam int MCB_EV_TRAP = 2;
    localparam int MCB_EV_HARDFAIL = 3;
    localparam int MCB_EV_W = 4;
    // ==========================================================
    // bus queue and reset values
    localparam int MCB_QDEPTH = 8;
    localparam int MCB_QIDX_W = 3;
    localparam logic [31:0] MCB_MASK_RST = 32'hffffffff;
    localparam logic [31:0] MCB_UNMAPPED_RD = 32'h00000000;
    localparam int MCB_POISON_DEPTH = 4;
    localparam int MCB_POISON_W = 32;
endpackage

/* File: mcb_queue.sv */
`timescale 1ns/1ps
// ==========================================================
// bus queue tracker: slots hold deferred transactions
module mcb_queue
    import mcb_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic alloc_valid,
    input wire logic [MCB_QIDX_W-1:0] alloc_idx,
    input wire logic done_valid,
    input wire logic [MCB_QIDX_W-1:0] done_idx,
    input wire logic hardfail_valid,
    input wire logic [MCB_QIDX_W-1:0] hardfail_idx,
    output logic [MCB_QDEPTH-1:0] busy,
    output logic stalled
);
    // ==========================================================
    // slot occupancy; a hard-failed slot is retired just like a
    // clean completion, otherwise the queue would wedge forever
    always_ff @(posedge core_clk) begin
        if (rst) begin
            busy <= '0;
        end else begin
            for (int i = 0; i < MCB_QDEPTH; i++) begin
                if (hardfail_valid && hardfail_idx == i[MCB_QIDX_W-1:0]) begin
                    busy[i] <= 1'b0; // RL2
                end else if (done_valid && done_idx == i[MCB_QIDX_W-1:0]) begin
                    busy[i] <= 1'b0;
                end else if (alloc_valid && alloc_idx == i[MCB_QIDX_W-1:0]) begin
                    busy[i] <= 1'b1;
                end
            end
        end
    end

    // core is stalled from one cycle after every slot is held
    always_ff @(posedge core_clk) begin
        if (rst) begin
            stalled <= 1'b0;
        end else begin
            stalled <= &busy;
        end
    end
endmodule // mcb_queue

/* File: mcb_bank_log.sv */
`timescale 1ns/1ps
// Summary of operation
// [RL1] detected errors are logged into banks
// [RL2] hard-failed deferred transaction leaves bus queue
// [RL3] prefetch tag error sets uncor, pcc, no trap
// [RL4] demand hit on poisoned line raises trap
// [RL5] bank two logs uncorrectables even when masked
// [RL6] all-zero bank-two mask suppresses its trap
module mcb_bank_log
    import mcb_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // bank-zero (l2 cache) error source
    input wire logic l2_err_valid,
    input wire logic l2_err_uncor,
    input wire logic l2_err_prefetch,
    input wire logic l2_err_tag,
    input wire logic [MCB_POISON_W-1:0] l2_err_addr,
    input wire logic [MCB_CODE_W-1:0] l2_err_code,
    // demand accesses checked against poisoned lines
    input wire logic demand_valid,
    input wire logic [MCB_POISON_W-1:0] demand_addr,
    // bank-two error source
    input wire logic b2_err_valid,
    input wire logic b2_err_uncor,
    input wire logic [MCB_CODE_W-1:0] b2_err_code,
    // bus queue events
    input wire logic bq_alloc_valid,
    input wire logic [MCB_QIDX_W-1:0] bq_alloc_idx,
    input wire logic bq_done_valid,
    input wire logic [MCB_QIDX_W-1:0] bq_done_idx,
    input wire logic bq_hardfail_valid,
    input wire logic [MCB_QIDX_W-1:0] bq_hardfail_idx,
    output logic bq_stalled,
    // toward core exception logic
    output logic machine_check_trap,
    output logic irq
);
    // ==========================================================
    // state
    logic [31:0] bank0_error_log_q; // bank-zero log
    logic [31:0] bank2_error_log_q; // bank-two log
    logic [31:0] bank2_report_enable_mask_q; // bank-two report mask
    logic [MCB_EV_W-1:0] irq_status_q; // sticky events
    logic [MCB_EV_W-1:0] irq_enable_q; // event enables
    logic [MCB_POISON_W-1:0] poison_addr_q [MCB_POISON_DEPTH]; // poisoned lines
    logic [MCB_POISON_DEPTH-1:0] poison_vld_q;
    logic [MCB_QDEPTH-1:0] bq_busy;
    logic bq_stall_w;
    logic wr_q; // registered write strobe
    logic [7:0] adr_q;
    logic [31:0] wdat_q;
    logic [MCB_EV_W-1:0] ev; // this cycle's events
    logic demand_hit;
    logic b2_trap;
    logic pf_err; // prefetch tag uncorrectable
    logic dm_err; // demand-visible uncorrectable
    logic log_clr0;
    logic log_clr2;
    logic [MCB_EV_W-1:0] ev_clr;

    // ==========================================================
    // helpers
    // byte-lane merge for a 32-bit write
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // fill a log word; only the first uncorrectable owns the log,
    // later errors just mark overflow so the original cause survives
    function automatic logic [31:0] log_update(input logic [31:0] old, input logic uncor,
                                               input logic pcc, input logic [MCB_CODE_W-1:0] code);
        logic [31:0] r;
        r = old;
        if (old[MCB_LOG_VALID_BIT]) begin
            r[MCB_LOG_OVER_BIT] = 1'b1;
        end
        if (!old[MCB_LOG_UNCOR_BIT]) begin
            r[MCB_LOG_VALID_BIT] = 1'b1;
            r[MCB_LOG_UNCOR_BIT] = uncor;
            r[MCB_LOG_PCC_BIT] = pcc;
            r[MCB_LOG_CODE_LSB +: MCB_CODE_W] = code;
        end
        return r;
    endfunction

    // ==========================================================
    // event decode
    always_comb begin
        pf_err = l2_err_valid && l2_err_uncor && l2_err_prefetch && l2_err_tag;
        dm_err = l2_err_valid && l2_err_uncor && !l2_err_prefetch;
        demand_hit = 1'b0;
        for (int i = 0; i < MCB_POISON_DEPTH; i++) begin
            if (demand_valid && poison_vld_q[i] && poison_addr_q[i] == demand_addr) begin
                demand_hit = 1'b1;
            end
        end
        // masked bank two still logs but never traps
        b2_trap = b2_err_valid && b2_err_uncor && (|bank2_report_enable_mask_q); // RL6
        ev = '0;
        ev[MCB_EV_BANK0] = l2_err_valid;
        ev[MCB_EV_BANK2] = b2_err_valid;
        ev[MCB_EV_TRAP] = dm_err || demand_hit || b2_trap;
        ev[MCB_EV_HARDFAIL] = bq_hardfail_valid;
        log_clr0 = wr_q && adr_q == MCB_LOG_CLEAR_OFF && wdat_q[0];
        log_clr2 = wr_q && adr_q == MCB_LOG_CLEAR_OFF && wdat_q[1];
        ev_clr = (wr_q && adr_q == MCB_IRQ_CLEAR_OFF) ? wdat_q[MCB_EV_W-1:0] : '0;
    end

    // ==========================================================
    // wishbone: one wait state, ack one cycle, then dropped
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wr_q <= 1'b0;
            adr_q <= '0;
            wdat_q <= '0;
        end else begin
            wr_q <= 1'b0;
            wb_ack_o <= 1'b0;
            if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
                wb_ack_o <= 1'b1;
                wr_q <= wb_we_i;
                adr_q <= wb_adr_i;
                wdat_q <= wb_dat_i;
            end
        end
    end

    // read data mux
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wb_dat_o <= '0;
        end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
            if (wb_adr_i == MCB_BANK0_LOG_OFF) begin
                wb_dat_o <= bank0_error_log_q;
            end else if (wb_adr_i == MCB_BANK2_LOG_OFF) begin
                wb_dat_o <= bank2_error_log_q;
            end else if (wb_adr_i == MCB_BANK2_MASK_OFF) begin
                wb_dat_o <= bank2_report_enable_mask_q;
            end else if (wb_adr_i == MCB_IRQ_STATUS_OFF) begin
                wb_dat_o <= {{(32-MCB_EV_W){1'b0}}, irq_status_q};
            end else if (wb_adr_i == MCB_IRQ_ENABLE_OFF) begin
                wb_dat_o <= {{(32-MCB_EV_W){1'b0}}, irq_enable_q};
            end else if (wb_adr_i == MCB_QUEUE_OFF) begin
                wb_dat_o <= {23'h000000, bq_stall_w, bq_busy};
            end else begin
                wb_dat_o <= MCB_UNMAPPED_RD; // write-only and unmapped
            end
        end
    end

    // ==========================================================
    // software-written control
    always_ff @(posedge core_clk) begin
        if (rst) begin
            bank2_report_enable_mask_q <= MCB_MASK_RST;
            irq_enable_q <= '0;
        end else if (wr_q) begin
            if (adr_q == MCB_BANK2_MASK_OFF) begin
                bank2_report_enable_mask_q <= wdat_q;
            end else if (adr_q == MCB_IRQ_ENABLE_OFF) begin
                irq_enable_q <= wdat_q[MCB_EV_W-1:0];
            end
        end
    end

    // ==========================================================
    // bank-zero log: a new error on the clear cycle wins
    always_ff @(posedge core_clk) begin
        if (rst) begin
            bank0_error_log_q <= '0;
        end else if (l2_err_valid) begin
            // prefetch tag errors carry uncor and pcc but no trap
            bank0_error_log_q <= log_update(log_clr0 ? 32'h00000000 : bank0_error_log_q,
                                            l2_err_uncor, pf_err || dm_err, l2_err_code); // RL1 RL3
        end else if (log_clr0) begin
            bank0_error_log_q <= '0;
        end
    end

    // bank-two log: records regardless of the report mask
    always_ff @(posedge core_clk) begin
        if (rst) begin
            bank2_error_log_q <= '0;
        end else if (b2_err_valid) begin
            bank2_error_log_q <= log_update(log_clr2 ? 32'h00000000 : bank2_error_log_q,
                                            b2_err_uncor, b2_err_uncor, b2_err_code); // RL5
        end else if (log_clr2) begin
            bank2_error_log_q <= '0;
        end
    end

    // ==========================================================
    // poisoned line table; round-robin replacement when full
    logic [1:0] poison_ptr_q;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            poison_vld_q <= '0;
            poison_ptr_q <= '0;
        end else if (pf_err) begin
            poison_addr_q[poison_ptr_q] <= l2_err_addr;
            poison_vld_q[poison_ptr_q] <= 1'b1;
            poison_ptr_q <= poison_ptr_q + 2'h1;
        end
    end

    // ==========================================================
    // trap and interrupt; set wins over clear
    always_ff @(posedge core_clk) begin
        if (rst) begin
            machine_check_trap <= 1'b0;
            irq_status_q <= '0;
            irq <= 1'b0;
        end else begin
            machine_check_trap <= ev[MCB_EV_TRAP]; // RL4
            irq_status_q <= (irq_status_q & ~ev_clr) | ev;
            irq <= |(((irq_status_q & ~ev_clr) | ev) & irq_enable_q);
        end
    end

    // ==========================================================
    // bus queue
    mcb_queue u_queue (
        .core_clk(core_clk),
        .rst(rst),
        .alloc_valid(bq_alloc_valid),
        .alloc_idx(bq_alloc_idx),
        .done_valid(bq_done_valid),
        .done_idx(bq_done_idx),
        .hardfail_valid(bq_hardfail_valid), // RL2
        .hardfail_idx(bq_hardfail_idx),
        .busy(bq_busy),
        .stalled(bq_stall_w)
    );

    // registered copy keeps the top output straight from a flop
    always_ff @(posedge core_clk) begin
        if (rst) begin
            bq_stalled <= 1'b0;
        end else begin
            bq_stalled <= bq_stall_w;
        end
    end
endmodule // mcb_bank_log

/* File: mcb_bank_log_asserts.sv */
`timescale 1ns/1ps
// ==========================================================
// port checker for the error logging block
module mcb_bank_log_asserts
    import mcb_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic l2_err_valid,
    input wire logic l2_err_uncor,
    input wire logic l2_err_prefetch,
    input wire logic demand_valid,
    input wire logic b2_err_valid,
    input wire logic bq_alloc_valid,
    input wire logic bq_hardfail_valid,
    input wire logic bq_stalled,
    input wire logic machine_check_trap
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // ==========================================================
    // register bus
    ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    unmapped_rd_a: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
        && wb_adr_i == 8'h20 |=> wb_dat_o == MCB_UNMAPPED_RD)
        else $error("unmapped read data");
    // ==========================================================
    // trap and queue; a trap always needs a cause one cycle earlier
    pf_no_trap_a: assert property (l2_err_valid && l2_err_prefetch && !demand_valid
        && !b2_err_valid |=> !machine_check_trap)
        else $error("prefetch error trapped");
    demand_trap_a: assert property (l2_err_valid && l2_err_uncor && !l2_err_prefetch
        |=> machine_check_trap)
        else $error("demand error not trapped");
    trap_cause_a: assert property (machine_check_trap
        |-> $past(l2_err_valid || demand_valid || b2_err_valid))
        else $error("trap without cause");
    // slot frees on the hard-fail edge, stall flop and output copy follow;
    // no refill on the next edge either, or the queue is full again
    stall_free_a: assert property (bq_hardfail_valid && !bq_alloc_valid
        ##1 !bq_alloc_valid |=> ##1 !bq_stalled)
        else $error("queue still stalled");
    cover property (machine_check_trap);
    cover property (bq_stalled);
    cover property (wb_ack_o && !wb_we_i);
endmodule // mcb_bank_log_asserts

bind mcb_bank_log mcb_bank_log_asserts chk (.core_clk, .rst, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .l2_err_valid, .l2_err_uncor,
    .l2_err_prefetch, .demand_valid, .b2_err_valid, .bq_alloc_valid,
    .bq_hardfail_valid, .bq_stalled, .machine_check_trap);

/* File: mcb_bus_model.sv */
`timescale 1ns/1ps
// ==========================================================
// system bus side: fills all slots, hard-fails one deferred
// transaction, then completes its neighbour normally
module mcb_bus_model
    import mcb_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic go,
    input wire logic [MCB_QIDX_W-1:0] fail_idx,
    output logic alloc_valid,
    output logic [MCB_QIDX_W-1:0] alloc_idx,
    output logic done_valid,
    output logic [MCB_QIDX_W-1:0] done_idx,
    output logic hardfail_valid,
    output logic [MCB_QIDX_W-1:0] hardfail_idx
);
    logic [4:0] cnt_q; // step counter, 1f means idle
    // sequence step; stops at idle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_q <= 5'h1f;
        end else if (go) begin
            cnt_q <= 5'h00;
        end else if (cnt_q != 5'h1f) begin
            cnt_q <= cnt_q + 5'h01;
        end
    end
    // idle hard-fail and done index lines show the inverted step count so stale values never look valid
    assign alloc_valid = cnt_q < 5'h08;
    assign alloc_idx = cnt_q[2:0];
    assign hardfail_valid = cnt_q == 5'h0c;
    assign hardfail_idx = hardfail_valid ? fail_idx : ~cnt_q[2:0];
    assign done_valid = cnt_q == 5'h0e;
    assign done_idx = done_valid ? fail_idx + 3'h1 : ~cnt_q[2:0];
endmodule // mcb_bus_model

/* File: mcb_bank_log_tb.sv */
`timescale 1ns/1ps
// ==========================================================
// self-checking bench for the error logging block
module mcb_bank_log_tb
    import mcb_pkg::*;
;
    typedef struct packed {logic [7:0] a; logic [31:0] e;} mcb_row_t;
    logic core_clk = 1'h0, rst = 1'h1, go = 1'h0;
    logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, wb_ack_o;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf; // full words only
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, l2_err_addr = 32'h0, demand_addr;
    logic l2_err_valid = 1'h0, l2_err_uncor = 1'h1, l2_err_prefetch = 1'h0;
    logic l2_err_tag = 1'h1, demand_valid = 1'h0, b2_err_valid = 1'h0, b2_err_uncor = 1'h1;
    logic [15:0] l2_err_code = 16'h0, b2_err_code;
    logic bq_alloc_valid, bq_done_valid, bq_hardfail_valid, bq_stalled;
    logic [2:0] bq_alloc_idx, bq_done_idx, bq_hardfail_idx, fail_idx = 3'h3;
    logic machine_check_trap, irq;
    int failures = 0, n_compared = 0;
    // reset contents, unmapped place last
    mcb_row_t rows [7] = '{'{MCB_BANK0_LOG_OFF, 32'h0}, '{MCB_BANK2_LOG_OFF, 32'h0},
        '{MCB_BANK2_MASK_OFF, MCB_MASK_RST}, '{MCB_IRQ_STATUS_OFF, 32'h0},
        '{MCB_IRQ_ENABLE_OFF, 32'h0}, '{MCB_QUEUE_OFF, 32'h0}, '{8'h20, MCB_UNMAPPED_RD}};
    assign demand_addr = l2_err_addr; // demand reuses the poisoned address
    assign b2_err_code = l2_err_code;
    initial forever #5 core_clk = ~core_clk;
    mcb_bank_log dut (.core_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .l2_err_valid, .l2_err_uncor,
        .l2_err_prefetch, .l2_err_tag, .l2_err_addr, .l2_err_code, .demand_valid,
        .demand_addr, .b2_err_valid, .b2_err_uncor, .b2_err_code, .bq_alloc_valid,
        .bq_alloc_idx, .bq_done_valid, .bq_done_idx, .bq_hardfail_valid,
        .bq_hardfail_idx, .bq_stalled, .machine_check_trap, .irq);
    mcb_bus_model bus (.core_clk, .rst, .go, .fail_idx, .alloc_valid(bq_alloc_valid),
        .alloc_idx(bq_alloc_idx), .done_valid(bq_done_valid), .done_idx(bq_done_idx),
        .hardfail_valid(bq_hardfail_valid), .hardfail_idx(bq_hardfail_idx));
    // ==========================================================
    // compare and report
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %0t word %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_bit(input logic g, input logic e);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %0t flag %b exp %b", $time, g, e);
        end
    endtask
    task automatic report_and_stop();
        if (failures == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ==========================================================
    // one classic cycle; read data lands in rd
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        if (n >= 20) begin
            failures++;
            report_and_stop();
        end
    endtask
    // one-cycle event: 0 prefetch tag, 1 demand hit, 2 demand error, 3 bank two
    task automatic fire(input int k);
        @(posedge core_clk);
        l2_err_valid <= k == 0 || k == 2;
        l2_err_prefetch <= k == 0;
        demand_valid <= k == 1;
        b2_err_valid <= k == 3;
        @(posedge core_clk);
        l2_err_valid <= 1'h0;
        demand_valid <= 1'h0;
        b2_err_valid <= 1'h0;
        #1;
    endtask
    task automatic settle();
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        rst <= 1'h0;
        foreach (rows[i]) begin
            wb(1'h0, rows[i].a, 32'h0);
            chk(rd, rows[i].e);
        end
        l2_err_addr <= 32'h00001040;
        l2_err_code <= 16'h00a5;
        fire(0);
        chk_bit(machine_check_trap, 1'h0);
        wb(1'h0, MCB_BANK0_LOG_OFF, 32'h0);
        chk(rd, (32'h00a5 << MCB_LOG_CODE_LSB) | 32'h7);
        fire(1);
        chk_bit(machine_check_trap, 1'h1);
        l2_err_addr <= 32'h00002080;
        fire(2);
        chk_bit(machine_check_trap, 1'h1);
        wb(1'h1, MCB_BANK2_MASK_OFF, 32'h0);
        l2_err_code <= 16'h005a;
        fire(3);
        chk_bit(machine_check_trap, 1'h0);
        wb(1'h0, MCB_BANK2_LOG_OFF, 32'h0);
        chk(rd & 32'hffff0003, 32'h005a0003);
        wb(1'h1, MCB_BANK2_MASK_OFF, 32'h1);
        fire(3);
        chk_bit(machine_check_trap, 1'h1);
        // the hard-failed slot must be freed or the queue stays blocked
        go <= 1'h1;
        @(posedge core_clk);
        go <= 1'h0;
        repeat (10) @(posedge core_clk);
        #1;
        chk_bit(bq_stalled, 1'h1);
        repeat (5) @(posedge core_clk);
        #1;
        chk_bit(bq_stalled, 1'h0);
        wb(1'h0, MCB_QUEUE_OFF, 32'h0);
        chk(rd, 32'h000000ff & ~(32'h3 << fail_idx));
        wb(1'h0, MCB_IRQ_STATUS_OFF, 32'h0);
        chk(rd, 32'hf);
        wb(1'h1, MCB_IRQ_ENABLE_OFF, 32'h1);
        settle();
        chk_bit(irq, 1'h1);
        wb(1'h1, MCB_IRQ_CLEAR_OFF, 32'h1);
        settle();
        chk_bit(irq, 1'h0);
        wb(1'h0, MCB_IRQ_STATUS_OFF, 32'h0);
        chk(rd, 32'he);
        // log clear command empties both banks
        wb(1'h1, MCB_LOG_CLEAR_OFF, 32'h3);
        wb(1'h0, MCB_BANK0_LOG_OFF, 32'h0);
        chk(rd, 32'h0);
        wb(1'h0, MCB_BANK2_LOG_OFF, 32'h0);
        chk(rd, 32'h0);
        // a second reset mid-run drops irq and restores the mask
        wb(1'h1, MCB_IRQ_ENABLE_OFF, 32'hf);
        settle();
        chk_bit(irq, 1'h1);
        @(posedge core_clk);
        rst <= 1'h1;
        repeat (3) @(posedge core_clk);
        rst <= 1'h0;
        #1;
        chk_bit(irq, 1'h0);
        wb(1'h0, MCB_BANK2_MASK_OFF, 32'h0);
        chk(rd, MCB_MASK_RST);
        report_and_stop();
    end
endmodule // mcb_bank_log_tb
